// >>> pkg/lofc_map.svh
// Register offsets, field positions and reset values of the lead-off and channel 1 bank
`ifndef LOFC_MAP_SVH
`define LOFC_MAP_SVH
`define LOFC_ADDR_W            8
`define LOFC_OFS_LEAD_OFF      8'h03
`define LOFC_OFS_CH1           8'h04
`define LOFC_OFS_TEST_CTRL     8'h10
`define LOFC_OFS_STATUS        8'h11
`define LOFC_LEAD_OFF_CONTROL_RESET        8'h10
`define LOFC_CH1_RESET         8'h00
`define LOFC_TEST_RESET        8'h00
`define LOFC_LEAD_OFF_CONTROL_FIXED_MASK   8'h12
`define LOFC_LEAD_OFF_CONTROL_FIXED_VAL    8'h10
`define LOFC_TH_MSB            7
`define LOFC_TH_LSB            5
`define LOFC_CUR_MSB           3
`define LOFC_CUR_LSB           2
`define LOFC_FREQ_BIT          0
`define LOFC_PD_BIT            7
`define LOFC_GAIN_MSB          6
`define LOFC_GAIN_LSB          4
`define LOFC_MUX_MSB           3
`define LOFC_MUX_LSB           0
`define LOFC_TEST_ON_BIT       1
`define LOFC_TEST_FREQUENCY_SELECT_BIT     0
`define LOFC_CLK_HZ            50000000
`define LOFC_TEST_HZ           1
`define LOFC_HALF_PERIOD_CYC   (`LOFC_CLK_HZ / (2 * `LOFC_TEST_HZ))
`endif

// >>> pkg/lofc_pkg.sv
// Types for the lead-off and channel 1 configuration bank
package lofc_pkg;
  typedef enum logic [3:0] {
    LOFC_MUX_NORMAL   = 4'h0,
    LOFC_MUX_SHORTED  = 4'h1,
    LOFC_MUX_DRV_MEAS = 4'h2,
    LOFC_MUX_SUPPLY   = 4'h3,
    LOFC_MUX_TEMP     = 4'h4,
    LOFC_MUX_TEST     = 4'h5,
    LOFC_MUX_DRV_POS  = 4'h6,
    LOFC_MUX_DRV_NEG  = 4'h7,
    LOFC_MUX_DRV_BOTH = 4'h8,
    LOFC_MUX_THIRD    = 4'h9
  } lofc_mux_t;
  typedef enum logic [1:0] {
    LOFC_TEST_OFF = 2'b00,
    LOFC_TEST_DC  = 2'b01,
    LOFC_TEST_SQ  = 2'b11
  } lofc_test_t;
endpackage

// >>> rtl/lofc_bank.sv
// Lead-off control and channel 1 settings register bank with decoded analog controls
// What this block does
// - Threshold code picks comparator pair 95/5 down to 70/30 percent, reset 000
// - Lead-off bit 0 clear selects dc detection, set selects ac
// - Channel 1 power-down bit 7 set powers channel down, reset clear
// - Gain code decodes 6,1,2,3,4,8,12; reset gives 6
// - Input codes 0 to 5: normal, shorted, drive meas, supply, temp, test
// - Code 0110 ties positive input to drive amplifier input node
// - Code 0111 ties negative input to drive amplifier input node
// - Code 1000 ties both inputs to drive amplifier input node
// - Code 1001 routes third input pair; code 1010 is reserved
// - Supply measure: channel 1 half analog supplies sum, channel 2 quarter digital
// - Test signal off unless enabled; then dc or 1 Hz square wave
`timescale 1ns/1ps
`include "lofc_map.svh"

module lofc_bank
  import lofc_pkg::*;
#(
  parameter int HALF_PERIOD_CYC = `LOFC_HALF_PERIOD_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [2:0]  comparator_threshold_code,
  output logic      [9:0]  comp_pos_permille,
  output logic      [9:0]  comp_neg_permille,
  output logic      [1:0]  excitation_current_select,
  output logic      [15:0] excitation_current_na,
  output logic             detect_frequency_select,
  output logic             ch1_power_down,
  output logic      [2:0]  ch1_gain_code,
  output logic      [3:0]  ch1_gain_value,
  output logic      [3:0]  ch1_input_select,
  output logic             sel_normal,
  output logic             sel_shorted,
  output logic             drive_amp_measurement,
  output logic             supply_monitor_input,
  output logic             sel_temperature,
  output logic             sel_test_signal,
  output logic             drive_node_positive,
  output logic             drive_node_negative,
  output logic             drive_node_both,
  output logic             third_input_positive,
  output logic             third_input_negative,
  output logic             sel_reserved,
  output logic             test_signal_level,
  output logic             test_signal_active
);

  // Elaboration checks: parameters and the field map must fit the logic
  if (HALF_PERIOD_CYC < 1)
  begin : g_bad_half_period
    $error("HALF_PERIOD_CYC must be at least 1");
  end

  if (`LOFC_ADDR_W != 8)
  begin : g_bad_addr_w
    $error("register address must be eight bits wide");
  end

  if (`LOFC_TH_MSB - `LOFC_TH_LSB != 2)
  begin : g_bad_th_field
    $error("threshold field must be three bits wide");
  end

  if (`LOFC_CUR_MSB - `LOFC_CUR_LSB != 1)
  begin : g_bad_cur_field
    $error("current field must be two bits wide");
  end

  if (`LOFC_GAIN_MSB - `LOFC_GAIN_LSB != 2)
  begin : g_bad_gain_field
    $error("gain field must be three bits wide");
  end

  if (`LOFC_MUX_MSB - `LOFC_MUX_LSB != 3)
  begin : g_bad_mux_field
    $error("input select field must be four bits wide");
  end

  if ((`LOFC_LEAD_OFF_CONTROL_FIXED_VAL & ~`LOFC_LEAD_OFF_CONTROL_FIXED_MASK) != 0)
  begin : g_bad_fixed_bits
    $error("fixed lead-off value lies outside its mask");
  end

  if ((`LOFC_LEAD_OFF_CONTROL_RESET & `LOFC_LEAD_OFF_CONTROL_FIXED_MASK) != `LOFC_LEAD_OFF_CONTROL_FIXED_VAL)
  begin : g_bad_lead_off_control_reset
    $error("lead-off reset value breaks the fixed bits");
  end

  if (`LOFC_OFS_LEAD_OFF == `LOFC_OFS_CH1
      || `LOFC_OFS_LEAD_OFF == `LOFC_OFS_TEST_CTRL
      || `LOFC_OFS_LEAD_OFF == `LOFC_OFS_STATUS
      || `LOFC_OFS_CH1 == `LOFC_OFS_TEST_CTRL
      || `LOFC_OFS_CH1 == `LOFC_OFS_STATUS
      || `LOFC_OFS_TEST_CTRL == `LOFC_OFS_STATUS)
  begin : g_bad_offsets
    $error("register offsets must all differ");
  end

  if (`LOFC_TEST_ON_BIT == `LOFC_TEST_FREQUENCY_SELECT_BIT)
  begin : g_bad_test_bits
    $error("test enable and frequency bits must differ");
  end

  if (`LOFC_PD_BIT <= `LOFC_GAIN_MSB)
  begin : g_bad_pd_bit
    $error("power-down bit overlaps the gain field");
  end

  localparam int CNT_W = (HALF_PERIOD_CYC > 1) ? $clog2(HALF_PERIOD_CYC) : 1;

  logic [7:0]       lead_off_control;
  logic [7:0]       channel1_settings;
  logic [7:0]       test_control;
  logic [CNT_W-1:0] half_cnt;
  logic             square;
  logic [7:0]       next_rdata;
  logic [15:0]      mux_hot;
  lofc_test_t       test_mode;

  // Register hit: strobe high with the address of one register
  function automatic logic lofc_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] ofs);
    lofc_hit = strobe && (addr == ofs);
  endfunction

  // Threshold code to positive-side level in tenths of a percent
  function automatic logic [9:0] lofc_pos_level(input logic [2:0] code);
    case (code)
      3'h0:    lofc_pos_level = 10'h3B6;
      3'h1:    lofc_pos_level = 10'h39D;
      3'h2:    lofc_pos_level = 10'h384;
      3'h3:    lofc_pos_level = 10'h36B;
      3'h4:    lofc_pos_level = 10'h352;
      3'h5:    lofc_pos_level = 10'h320;
      3'h6:    lofc_pos_level = 10'h2EE;
      default: lofc_pos_level = 10'h2BC;
    endcase
  endfunction

  // Current code to excitation current in nanoampere
  function automatic logic [15:0] lofc_cur_na(input logic [1:0] code);
    case (code)
      2'h0:    lofc_cur_na = 16'h0006;
      2'h1:    lofc_cur_na = 16'h0016;
      2'h2:    lofc_cur_na = 16'h1770;
      default: lofc_cur_na = 16'h55F0;
    endcase
  endfunction

  // Gain code to amplifier gain; the undefined code 111 gives zero
  function automatic logic [3:0] lofc_gain(input logic [2:0] code);
    case (code)
      3'h0:    lofc_gain = 4'h6;
      3'h1:    lofc_gain = 4'h1;
      3'h2:    lofc_gain = 4'h2;
      3'h3:    lofc_gain = 4'h3;
      3'h4:    lofc_gain = 4'h4;
      3'h5:    lofc_gain = 4'h8;
      3'h6:    lofc_gain = 4'hC;
      default: lofc_gain = 4'h0;
    endcase
  endfunction

  // Input selection code match
  function automatic logic lofc_mux_is(input logic [3:0] code, input lofc_mux_t sel);
    lofc_mux_is = (code == sel);
  endfunction

  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lead_off_control <= `LOFC_LEAD_OFF_CONTROL_RESET;
    end
    else if (lofc_hit(reg_wr, reg_addr, `LOFC_OFS_LEAD_OFF))
    begin
      // Fixed bits keep their required values whatever is written
      lead_off_control <= (reg_wdata & ~`LOFC_LEAD_OFF_CONTROL_FIXED_MASK) | `LOFC_LEAD_OFF_CONTROL_FIXED_VAL;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel1_settings <= `LOFC_CH1_RESET;
    end
    else if (lofc_hit(reg_wr, reg_addr, `LOFC_OFS_CH1))
    begin
      channel1_settings <= reg_wdata;
    end
  end

  // Only the test enable and frequency bits are stored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_control <= `LOFC_TEST_RESET;
    end
    else if (lofc_hit(reg_wr, reg_addr, `LOFC_OFS_TEST_CTRL))
    begin
      test_control <= {6'h00, reg_wdata[1:0]};
    end
  end

  // Read port: data stand one cycle after the strobe, zero otherwise
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `LOFC_OFS_LEAD_OFF:  next_rdata = lead_off_control;
        `LOFC_OFS_CH1:       next_rdata = channel1_settings;
        `LOFC_OFS_TEST_CTRL: next_rdata = test_control;
        `LOFC_OFS_STATUS:    next_rdata = {6'h00, test_signal_active, test_signal_level};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Lead-off decode
  always_comb
  begin
    comparator_threshold_code = lead_off_control[`LOFC_TH_MSB:`LOFC_TH_LSB];
    comp_pos_permille         = lofc_pos_level(comparator_threshold_code);
    comp_neg_permille         = 10'h3E8 - comp_pos_permille;
    excitation_current_select = lead_off_control[`LOFC_CUR_MSB:`LOFC_CUR_LSB];
    excitation_current_na     = lofc_cur_na(excitation_current_select);
    detect_frequency_select   = lead_off_control[`LOFC_FREQ_BIT];
  end

  // Channel 1 fields
  always_comb
  begin
    // Shorting the inputs before power-down is left to software
    ch1_power_down   = channel1_settings[`LOFC_PD_BIT];
    ch1_gain_code    = channel1_settings[`LOFC_GAIN_MSB:`LOFC_GAIN_LSB];
    ch1_input_select = channel1_settings[`LOFC_MUX_MSB:`LOFC_MUX_LSB];
    // Gain is not forced to unity for supply measurement; software keeps that
    ch1_gain_value   = lofc_gain(ch1_gain_code);
  end

  // One decode line per input selection code
  for (genvar g = 0; g < 16; g++)
  begin : g_mux_hot
    assign mux_hot[g] = lofc_mux_is(ch1_input_select, lofc_mux_t'(4'(g)));
  end

  // Plain input routings, codes 0 to 5
  always_comb
  begin
    sel_normal            = mux_hot[LOFC_MUX_NORMAL];
    sel_shorted           = mux_hot[LOFC_MUX_SHORTED];
    drive_amp_measurement = mux_hot[LOFC_MUX_DRV_MEAS];
    // Channel 1 monitor sees half the analog supply sum; channel 2 lies outside
    supply_monitor_input  = mux_hot[LOFC_MUX_SUPPLY];
    sel_temperature       = mux_hot[LOFC_MUX_TEMP];
    sel_test_signal       = mux_hot[LOFC_MUX_TEST];
  end

  // Drive amplifier node routings; code 1000 raises both sides
  always_comb
  begin
    drive_node_both     = mux_hot[LOFC_MUX_DRV_BOTH];
    drive_node_positive = mux_hot[LOFC_MUX_DRV_POS] || mux_hot[LOFC_MUX_DRV_BOTH];
    drive_node_negative = mux_hot[LOFC_MUX_DRV_NEG] || mux_hot[LOFC_MUX_DRV_BOTH];
  end

  // Third pair routing; codes 1010 and up are reserved and route nothing
  always_comb
  begin
    third_input_positive = mux_hot[LOFC_MUX_THIRD];
    third_input_negative = mux_hot[LOFC_MUX_THIRD];
    sel_reserved         = |mux_hot[15:10];
  end

  // Test signal mode from the enable and frequency bits
  always_comb
  begin
    case ({test_control[`LOFC_TEST_ON_BIT], test_control[`LOFC_TEST_FREQUENCY_SELECT_BIT]})
      2'b10:   test_mode = LOFC_TEST_DC;
      2'b11:   test_mode = LOFC_TEST_SQ;
      default: test_mode = LOFC_TEST_OFF;
    endcase
  end

  // 1 Hz square wave; counter and level restart whenever the mode leaves square
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt <= '0;
      square   <= 1'b0;
    end
    else if (test_mode != LOFC_TEST_SQ)
    begin
      half_cnt <= '0;
      square   <= 1'b0;
    end
    else if (half_cnt == CNT_W'(HALF_PERIOD_CYC - 1))
    begin
      half_cnt <= '0;
      square   <= ~square;
    end
    else
    begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // Test signal outputs
  always_comb
  begin
    test_signal_active = (test_mode != LOFC_TEST_OFF);
    test_signal_level  = (test_mode == LOFC_TEST_DC) || (test_mode == LOFC_TEST_SQ && square);
  end

endmodule // lofc_bank

// >>> dv/lofc_bank_properties.sv
// Port assertions for the lead-off and channel 1 bank
`timescale 1ns/1ps
module lofc_bank_properties
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] comp_pos_permille,
  input wire logic [9:0] comp_neg_permille,
  input wire logic       detect_frequency_select,
  input wire logic       ch1_power_down,
  input wire logic [2:0] ch1_gain_code,
  input wire logic [3:0] ch1_gain_value,
  input wire logic [3:0] ch1_input_select,
  input wire logic       drive_node_positive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_thresh_sum: assert property (comp_pos_permille + comp_neg_permille == 11'h3E8)
    else $error("threshold pair off");
  chk_freq_wr: assert property (reg_wr && reg_addr == 8'h03 |=>
    {7'h00, detect_frequency_select} == ($past(reg_wdata) & 8'h01)) else $error("freq bit");
  chk_ch1_wr: assert property (reg_wr && reg_addr == 8'h04 |=>
    {ch1_power_down, ch1_gain_code, ch1_input_select} == $past(reg_wdata)) else $error("ch1");
  chk_gain_unity: assert property (ch1_gain_code == 3'h1 |-> ch1_gain_value == 4'h1)
    else $error("gain one");
  chk_gain_top: assert property (ch1_gain_code == 3'h6 |-> ch1_gain_value == 4'hC)
    else $error("gain twelve");
  chk_mux_hold: assert property (!reg_wr |=> $stable(ch1_input_select))
    else $error("mux moved");
  chk_drive_pos: assert property (ch1_input_select == 4'h6 |-> drive_node_positive)
    else $error("drive pos");
  chk_fixed_bits: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata[4] && !reg_rdata[1])
    else $error("fixed bits");
endmodule // lofc_bank_properties
bind lofc_bank lofc_bank_properties i_chk (.*);

// >>> dv/lofc_bank_tb.sv
// Self-checking bench for the lead-off and channel 1 bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("MISMATCH %s exp %0d got %0d", nm, ex, got); \
    end \
  end

module lofc_bank_tb;
  localparam int HALF = 4;
  logic        clk_sys, rst_n, reg_wr, reg_rd, detect_frequency_select, ch1_power_down;
  logic        sel_normal, sel_shorted, drive_amp_measurement, supply_monitor_input;
  logic        sel_temperature, sel_test_signal, drive_node_positive, drive_node_negative;
  logic        drive_node_both, third_input_positive, third_input_negative, sel_reserved;
  logic        test_signal_level, test_signal_active;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  comparator_threshold_code, ch1_gain_code;
  logic [9:0]  comp_pos_permille, comp_neg_permille;
  logic [1:0]  excitation_current_select;
  logic [15:0] excitation_current_na;
  logic [3:0]  ch1_gain_value, ch1_input_select;
  int          err_count, n_checks, m_lead_off_control, m_ch1, m_test, mux, v, e;
  int          pos_tab[8] = '{950, 925, 900, 875, 850, 800, 750, 700};
  int          cur_tab[4] = '{6, 22, 6000, 22000};
  int          gain_tab[8] = '{6, 1, 2, 3, 4, 8, 12, 0};
  int          adr_tab[4] = '{3, 4, 5, 16};
  logic [5:0]  low_sel;
  assign low_sel = {sel_test_signal, sel_temperature, supply_monitor_input,
                    drive_amp_measurement, sel_shorted, sel_normal};

  lofc_bank #(.HALF_PERIOD_CYC(HALF)) i_lofc_bank (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic results();
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == 8'h03) m_lead_off_control = (d & 8'hED) | 8'h10;
    if (a == 8'h04) m_ch1 = d;
    if (a == 8'h10) m_test = d & 8'h03;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    e = (a == 8'h03) ? m_lead_off_control : (a == 8'h04) ? m_ch1 : (a == 8'h10) ? m_test : 0;
    if (a == 8'h11) e = (m_test == 2) ? 3 : 0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask

  // Software side keeps power-down and supply measurement settings sane
  function automatic logic [7:0] legal(input int d);
    if (d[7]) d = (d & 8'hF0) | 1;
    if ((d & 15) == 3) d = (d & 8'h8F) | 8'h10;
    return 8'(d);
  endfunction

  task automatic check_all();
    mux = m_ch1 & 15;
    `CHK("thcode", m_lead_off_control >> 5, comparator_threshold_code)
    `CHK("cursel", (m_lead_off_control >> 2) & 3, excitation_current_select)
    `CHK("pos", pos_tab[m_lead_off_control >> 5], comp_pos_permille)
    `CHK("neg", 1000 - pos_tab[m_lead_off_control >> 5], comp_neg_permille)
    `CHK("cur", cur_tab[(m_lead_off_control >> 2) & 3], excitation_current_na)
    `CHK("ac", m_lead_off_control & 1, detect_frequency_select)
    `CHK("pd", m_ch1 >> 7, ch1_power_down)
    `CHK("gain", gain_tab[(m_ch1 >> 4) & 7], ch1_gain_value)
    `CHK("mux", (mux < 6) ? 1 << mux : 0, low_sel)
    `CHK("drv", (mux == 8) ? 7 : (mux == 7) ? 2 : (mux == 6) ? 1 : 0,
         {drive_node_both, drive_node_negative, drive_node_positive})
    `CHK("third", (mux == 9) ? 6 : (mux > 9) ? 1 : 0,
         {third_input_negative, third_input_positive, sel_reserved})
    `CHK("tst", m_test >> 1, test_signal_active)
    if (m_test == 2) `CHK("dc", 1, test_signal_level)
  endtask

  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_count, n_checks, m_ch1, m_test} = '0;
    m_lead_off_control = 8'h10;
    v = $urandom(32'h87C053BB);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check_all();
    for (int i = 0; i < 256; i++)
    begin
      wr(8'h03, 8'(i));
      wr(8'h04, 8'(i[7] ? (i & 8'hF0) | 1 : i));
      check_all();
      rd(8'h03);
    end
    repeat (300)
    begin
      v = $urandom;
      wr(8'(adr_tab[v & 3]), legal(v >> 8));
      check_all();
      rd(8'(adr_tab[(v >> 4) & 3]));
    end
    wr(8'h10, 8'h03);
    v = test_signal_level;
    mux = 0;
    while (test_signal_level === v[0] && mux < 3 * HALF)
    begin
      @(posedge clk_sys);
      #1;
      mux++;
    end
    v = test_signal_level;
    for (int k = 1; k <= HALF; k++)
    begin
      @(posedge clk_sys);
      #1;
      `CHK("square", (k < HALF) ? v : v ^ 1, test_signal_level)
    end
    wr(8'h10, 8'h02);
    rd(8'h11);
    wr(8'h10, 8'h00);
    check_all();
    rd(8'h11);
    results();
  end

  // About fourteen times the expected run
  initial
  begin
    #400000;
    err_count++;
    results();
  end
endmodule // lofc_bank_tb
